//--- core/sms_pkg.sv
// Purpose: Shared constants and types of the supply monitor block
// Assumes: 8-bit registers, 6-bit register addresses
// Notes:   Offsets live here only; status_val hard-codes bit positions, and par, pll and read data resets are literals
package sms_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [5:0] STATUS_ADDR = 6'h01;
    localparam logic [5:0] CFG_FIRST = 6'h04;
    localparam logic [5:0] CFG_LAST = 6'h27;
    localparam int CFG_COUNT = 36;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Status register fields
    // ----------------------------------------------------------------
    localparam int ST_BIT_ONE = 7;
    localparam int ST_BIT_LOWBAT21 = 5;
    localparam int ST_BIT_LOWBAT24 = 4;
    localparam int ST_BIT_DROP = 2;
    localparam int ST_BIT_PAR = 1;
    localparam int ST_BIT_PLL = 0;
    localparam logic DROP_FLAG_RESET = 1'b1;
    localparam logic LOWBAT_RESET = 1'b0;

    // ----------------------------------------------------------------
    // Comparator inputs, in synchroniser order
    // ----------------------------------------------------------------
    localparam int CMP_REGSUP_ACT = 0;
    localparam int CMP_REGSUP_STBY = 1;
    localparam int CMP_VBAT_STBY = 2;
    localparam int CMP_LOWBAT24 = 3;
    localparam int CMP_LOWBAT21 = 4;
    localparam int NUM_CMP = 5;
    localparam int SYNC_STAGES = 2;

    // Operating states of the system controller
    typedef enum logic [1:0] {
        ST_POR,
        ST_STANDBY,
        ST_ACTIVE,
        ST_SLEEP
    } sms_state_t;
endpackage

//--- core/sms_cmp_if.sv
// Purpose: Carries synchronised comparator levels between modules
// Assumes: Both ends on i_sys_clk
// Notes:   One bit per comparator, order as in the package
interface sms_cmp_if;
    import sms_pkg::*;
    logic [NUM_CMP-1:0] level;
    modport src (output level);
    modport dst (input level);
endinterface

//--- core/sms_cmp_sync.sv
// Purpose: Two-stage synchronisers for the analog comparator outputs
// Assumes: Comparator outputs are asynchronous levels
// Notes:   First stage is read by the second stage only
module sms_cmp_sync
    import sms_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    // Raw comparator levels
    input wire logic [NUM_CMP-1:0] i_raw,
    // Synchronised levels
    sms_cmp_if.src o_cmp
);
    // ----------------------------------------------------------------
    // Per-comparator synchroniser chain
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g++) begin : g_sync
            logic meta;
            logic stable;
            logic next_meta;
            logic next_stable;
            // Hold both stages while the clock enable is low
            always_comb begin
                next_meta = i_clk_en ? i_raw[g] : meta;
                next_stable = i_clk_en ? meta : stable;
            end
            // Two flops before any logic sees the level
            always_ff @(posedge i_sys_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    meta <= 1'b0;
                    stable <= 1'b0;
                end else begin
                    meta <= next_meta;
                    stable <= next_stable;
                end
            end
            assign o_cmp.level[g] = stable;
        end
    endgenerate
endmodule

//--- core/sms_supply_monitor.sv
// Purpose: Supply supervision, fail-safe and low-power state control
// Assumes: Register port is driven by the serial bus block on i_sys_clk
// Notes:   Overview of operation below; pa enable is combinational
//
// Overview of operation
// - Dropout kills amplifier, resets configuration registers
// - Dropout restarts controller from power-up state
// - Dropout recorded in status bit 2
// - Active watches regulator; standby watches both supplies
// - Two low-battery flags in status bits 5:4
// - New transmission start clears both low-battery flags
// - Low-battery monitor evaluates only in active
// - Standby keeps bus, registers, controller powered
// - Sleep keeps bus only; registers lost
// - Host configures via register writes; device applies
// - Dropout flag reads one after a dropout
// - Low-battery flags invalid during standby
module sms_supply_monitor
    import sms_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    // Analog comparator outputs (asynchronous)
    input wire logic i_regsup_low_act,
    input wire logic i_regsup_low_stby,
    input wire logic i_vbat_low_stby,
    input wire logic i_vbat_below_2v4,
    input wire logic i_vbat_below_2v1,
    // Controller requests (same clock, one-cycle pulses)
    input wire logic i_tx_start,
    input wire logic i_tx_end,
    input wire logic i_sleep_req,
    input wire logic i_wake_req,
    // Fault events from other blocks (one-cycle pulses)
    input wire logic i_pll_err,
    input wire logic i_par_err,
    // Register port from the serial bus block
    input wire logic [5:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // Device control outputs
    output logic o_pa_en,
    output sms_state_t o_state,
    output logic o_lowbat_valid,
    output logic [CFG_COUNT*8-1:0] o_config
);
    // ----------------------------------------------------------------
    // Comparator synchronisation
    // ----------------------------------------------------------------
    sms_cmp_if cmp_if ();
    sms_cmp_sync u_sync (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_clk_en(i_clk_en),
        .i_raw({i_vbat_below_2v1, i_vbat_below_2v4, i_vbat_low_stby,
                i_regsup_low_stby, i_regsup_low_act}),
        .o_cmp(cmp_if.src)
    );
    logic [NUM_CMP-1:0] cmp;
    assign cmp = cmp_if.level;

    // ----------------------------------------------------------------
    // State, flags and configuration bank
    // ----------------------------------------------------------------
    sms_state_t state, next_state;
    logic drop_flag, next_drop_flag;
    logic par_flag, next_par_flag;
    logic pll_flag, next_pll_flag;
    logic [1:0] lowbat, next_lowbat;
    logic [7:0] cfg [CFG_COUNT];
    logic [7:0] next_cfg [CFG_COUNT];
    logic [7:0] rdata, next_rdata;
    logic dropout_evt;
    logic tx_go;
    logic stat_rd;
    logic cfg_hit;
    logic [5:0] cfg_idx;
    logic [7:0] status_val;

    // Detector source depends on power state
    always_comb begin
        if (state == ST_ACTIVE) begin
            dropout_evt = cmp[CMP_REGSUP_ACT];
        end else begin
            dropout_evt = cmp[CMP_REGSUP_STBY] | cmp[CMP_VBAT_STBY];
        end
    end

    // Amplifier dies in the same cycle the dropout is seen
    assign o_pa_en = (state == ST_ACTIVE) && !dropout_evt;
    assign o_state = state;
    // Flags only meaningful in active; host ignores them otherwise
    assign o_lowbat_valid = (state == ST_ACTIVE);

    assign tx_go = (state == ST_STANDBY) && i_tx_start && !dropout_evt;
    assign stat_rd = i_reg_rd && (i_reg_addr == STATUS_ADDR);
    assign cfg_hit = (i_reg_addr >= CFG_FIRST) && (i_reg_addr <= CFG_LAST);
    assign cfg_idx = i_reg_addr - CFG_FIRST;
    assign status_val = {1'b1, 1'b0, lowbat[1], lowbat[0], 1'b0,
                         drop_flag, par_flag, pll_flag};

    // Controller sequencing; dropout has top priority
    always_comb begin
        next_state = state;
        if (dropout_evt) begin
            next_state = ST_POR;
        end else begin
            unique case (state)
                ST_POR: next_state = ST_STANDBY;
                ST_STANDBY: begin
                    if (i_tx_start) begin
                        next_state = ST_ACTIVE;
                    end else if (i_sleep_req) begin
                        next_state = ST_SLEEP;
                    end
                end
                ST_ACTIVE: begin
                    if (i_tx_end) begin
                        next_state = ST_STANDBY;
                    end
                end
                ST_SLEEP: begin
                    if (i_wake_req) begin
                        next_state = ST_STANDBY;
                    end
                end
            endcase
        end
    end

    // Sticky status flags; a set in the read cycle wins over clear
    always_comb begin
        next_drop_flag = stat_rd ? 1'b0 : drop_flag;
        next_par_flag = stat_rd ? 1'b0 : par_flag;
        next_pll_flag = stat_rd ? 1'b0 : pll_flag;
        if (dropout_evt) begin
            next_drop_flag = 1'b1;
        end
        if (i_par_err) begin
            next_par_flag = 1'b1;
        end
        if (i_pll_err) begin
            next_pll_flag = 1'b1;
        end
    end

    // Low-battery flags: cleared at start, sampled only in active
    always_comb begin
        next_lowbat = lowbat;
        if (tx_go) begin
            next_lowbat = 2'b00;
        end else if (state == ST_ACTIVE) begin
            // Threshold flags set independently and stay set
            next_lowbat = lowbat | {cmp[CMP_LOWBAT21], cmp[CMP_LOWBAT24]};
        end
    end

    // Configuration bank: host writes, lost in sleep or dropout
    always_comb begin
        for (int i = 0; i < CFG_COUNT; i++) begin
            next_cfg[i] = cfg[i];
        end
        if (dropout_evt || state == ST_SLEEP || state == ST_POR) begin
            for (int i = 0; i < CFG_COUNT; i++) begin
                next_cfg[i] = CFG_RESET;
            end
        end else if (i_reg_wr && cfg_hit) begin
            next_cfg[cfg_idx] = i_reg_wdata;
        end
    end

    // Read data registered; unmapped addresses read zero
    always_comb begin
        next_rdata = rdata;
        if (i_reg_rd) begin
            if (i_reg_addr == STATUS_ADDR) begin
                next_rdata = status_val;
            end else if (cfg_hit) begin
                next_rdata = cfg[cfg_idx];
            end else begin
                next_rdata = 8'h00;
            end
        end
    end

    // Register everything; low clock enable freezes all of it
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= ST_POR;
            drop_flag <= DROP_FLAG_RESET;
            par_flag <= 1'b0;
            pll_flag <= 1'b0;
            lowbat <= {LOWBAT_RESET, LOWBAT_RESET};
            rdata <= 8'h00;
            for (int i = 0; i < CFG_COUNT; i++) begin
                cfg[i] <= CFG_RESET;
            end
        end else if (i_clk_en) begin
            state <= next_state;
            drop_flag <= next_drop_flag;
            par_flag <= next_par_flag;
            pll_flag <= next_pll_flag;
            lowbat <= next_lowbat;
            rdata <= next_rdata;
            for (int i = 0; i < CFG_COUNT; i++) begin
                cfg[i] <= next_cfg[i];
            end
        end
    end

    assign o_reg_rdata = rdata;

    // Flatten the bank so downstream blocks apply it
    genvar g;
    generate
        for (g = 0; g < CFG_COUNT; g++) begin : g_cfg_out
            assign o_config[g*8 +: 8] = cfg[g];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);

    a_pa_off_drop: assert property (dropout_evt |-> !o_pa_en)
        else $error("amplifier on during dropout");
    a_cfg_cleared: assert property (
        dropout_evt && i_clk_en |=> cfg[0] == CFG_RESET
            && cfg[CFG_COUNT-1] == CFG_RESET)
        else $error("configuration kept after dropout");
    // A lingering dropout or a frozen edge keeps the controller in POR
    a_restart_por: assert property (
        dropout_evt && i_clk_en |=> state == ST_POR ##1 !$past(i_clk_en)
            || $past(dropout_evt) || state == ST_STANDBY)
        else $error("no restart from power-up state");
    a_drop_flag_set: assert property (
        dropout_evt && i_clk_en |=> drop_flag)
        else $error("dropout flag not set");
    a_drop_flag_read: assert property (
        stat_rd && i_clk_en && drop_flag |=> o_reg_rdata[ST_BIT_DROP])
        else $error("dropout not seen in status");
    a_standby_watch: assert property (
        state == ST_STANDBY && cmp[CMP_VBAT_STBY] |-> dropout_evt)
        else $error("battery dropout missed in standby");
    a_active_ignore: assert property (
        state == ST_ACTIVE && !cmp[CMP_REGSUP_ACT] |-> !dropout_evt)
        else $error("active dropout from wrong supply");
    a_lowbat_set: assert property (
        state == ST_ACTIVE && cmp[CMP_LOWBAT21] && i_clk_en |=> lowbat[1])
        else $error("low-battery flag not set");
    a_lowbat_clear: assert property (
        tx_go && i_clk_en |=> lowbat == 2'b00)
        else $error("low-battery flags not cleared at start");
    a_lowbat_frozen: assert property (
        state != ST_ACTIVE && !tx_go |=> lowbat == $past(lowbat))
        else $error("low-battery flags changed outside active");
    a_sleep_lost: assert property (
        state == ST_SLEEP && i_clk_en |=> cfg[CFG_COUNT-1] == CFG_RESET)
        else $error("configuration retained in sleep");
    a_cfg_write: assert property (
        i_reg_wr && i_reg_addr == CFG_FIRST && i_clk_en && !dropout_evt
            && state inside {ST_STANDBY, ST_ACTIVE}
            |=> cfg[0] == $past(i_reg_wdata))
        else $error("configuration write not applied");

    c_drop_active: cover property (state == ST_ACTIVE && dropout_evt);
    c_tx_cycle: cover property (tx_go ##[1:20] state == ST_STANDBY);
    c_sleep_wake: cover property (state == ST_SLEEP ##[1:20]
        state == ST_STANDBY);
    c_status_read: cover property (stat_rd && drop_flag);
endmodule

//--- verif/sms_host_model.sv
// Purpose: Host side of the register port, byte reads and writes
// Assumes: Same clock as the device, one access per request
// Notes:   Write data is inverted once released, so no stale byte
module sms_host_model (
    // Clock
    input wire logic i_sys_clk,
    // Register port towards the device
    output logic [5:0] o_reg_addr,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [7:0] o_reg_wdata,
    // Read data has landed, one cycle
    output logic o_rd_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial begin
        o_reg_addr = 6'h00;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_wdata = 8'h00;
        o_rd_valid = 1'b0;
    end

    // Configuration only through register writes
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        o_reg_addr <= a;
        o_reg_wdata <= d;
        o_reg_wr <= 1'b1;
        @(posedge i_sys_clk);
        o_reg_wr <= 1'b0;
        o_reg_wdata <= ~d; // Released, old byte not kept
    endtask

    // Read strobe, data valid one cycle later
    task automatic rd(input logic [5:0] a);
        @(posedge i_sys_clk);
        o_reg_addr <= a;
        o_reg_rd <= 1'b1;
        @(posedge i_sys_clk);
        o_reg_rd <= 1'b0;
        o_rd_valid <= 1'b1;
        @(posedge i_sys_clk);
        o_rd_valid <= 1'b0;
    endtask
endmodule

//--- verif/test_supply_monitor_failsafe.sv
// Purpose: Self-checking bench of the supply monitor block
// Assumes: Host model owns the register port
// Notes:   Reads are checked from a queue of expected bytes
module test_supply_monitor_failsafe import sms_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic i_sys_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_clk_en = 1'b1;
    logic [NUM_CMP-1:0] raw = '0; // Comparator levels
    logic [3:0] req = '0; // start, end, sleep, wake
    logic [1:0] ev = '0; // pll, parity
    logic [5:0] addr;
    logic wr, rd, rv, pa_en, lowbat_valid;
    logic [7:0] wdata, rdata;
    sms_state_t state;
    logic [CFG_COUNT*8-1:0] cfg;
    logic [CFG_COUNT*8-1:0] exp_cfg = '0;
    logic [7:0] q[$];
    int errors = 0;
    int samples_checked = 0;

    always #5 i_sys_clk = ~i_sys_clk;

    sms_host_model host (.i_sys_clk(i_sys_clk), .o_reg_addr(addr),
        .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_wdata(wdata),
        .o_rd_valid(rv));

    sms_supply_monitor dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
        .i_clk_en(i_clk_en), .i_regsup_low_act(raw[CMP_REGSUP_ACT]),
        .i_regsup_low_stby(raw[CMP_REGSUP_STBY]),
        .i_vbat_low_stby(raw[CMP_VBAT_STBY]),
        .i_vbat_below_2v4(raw[CMP_LOWBAT24]),
        .i_vbat_below_2v1(raw[CMP_LOWBAT21]), .i_tx_start(req[0]),
        .i_tx_end(req[1]), .i_sleep_req(req[2]), .i_wake_req(req[3]),
        .i_pll_err(ev[0]), .i_par_err(ev[1]), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_pa_en(pa_en), .o_state(state),
        .o_lowbat_valid(lowbat_valid), .o_config(cfg));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_cfg();
        samples_checked++;
        if (cfg !== exp_cfg) begin
            errors++;
            $display("Error config expected %h seen %h", exp_cfg, cfg);
        end
    endtask

    task automatic close_out();
        if (q.size() != 0) errors++; // Reads that never landed
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Edges pass, then settle before looking
    task automatic step(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask

    task automatic rx(input logic [5:0] a, input logic [7:0] e);
        q.push_back(e);
        host.rd(a);
    endtask

    task automatic pulse(input int i);
        @(posedge i_sys_clk);
        req[i] <= 1'b1;
        @(posedge i_sys_clk);
        req[i] <= 1'b0;
        #1;
    endtask

    task automatic setraw(input int i, input logic v);
        @(posedge i_sys_clk);
        raw[i] <= v;
    endtask

    // Only the mapped bank takes writes
    task automatic wcfg(input logic [5:0] a, input logic [7:0] d);
        host.wr(a, d);
        if (a >= CFG_FIRST && a <= CFG_LAST)
            exp_cfg[(a - CFG_FIRST) * 8 +: 8] = d;
        #1;
        chk_cfg();
    endtask

    // Oldest expected byte meets the landed read data
    always @(posedge i_sys_clk) begin
        if (rv === 1'b1 && q.size() > 0) begin
            chk("rdata", q.pop_front(), rdata);
        end
    end

    // Watchdog, far beyond the few hundred cycles needed
    initial begin
        #100000;
        errors++;
        close_out();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h52D2));
        repeat (8) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        step(2);
        chk("state", ST_STANDBY, state);
        chk("pa", 0, pa_en);
        chk_cfg();
        rx(STATUS_ADDR, 8'h84);
        rx(STATUS_ADDR, 8'h80);
        rx(6'h3F, 8'h00);
        @(posedge i_sys_clk);
        ev <= 2'b11;
        @(posedge i_sys_clk);
        ev <= 2'b00;
        rx(STATUS_ADDR, 8'h83);
        host.wr(STATUS_ADDR, 8'hFF); // Status is read-only
        rx(STATUS_ADDR, 8'h80);
        for (int i = 0; i < CFG_COUNT; i++)
            wcfg(6'(CFG_FIRST + i), 8'($urandom));
        wcfg(6'h28, 8'hA5);
        wcfg(6'h03, 8'h5A);
        // Standby ignores the active threshold and the battery monitor
        setraw(CMP_REGSUP_ACT, 1'b1);
        setraw(CMP_LOWBAT21, 1'b1);
        step(4);
        chk("state", ST_STANDBY, state);
        chk_cfg();
        rx(STATUS_ADDR, 8'h80);
        setraw(CMP_REGSUP_ACT, 1'b0);
        setraw(CMP_LOWBAT21, 1'b0);
        step(3);
        pulse(0);
        chk("state", ST_ACTIVE, state);
        chk("pa", 1, pa_en);
        chk("lowbat_valid", 1, lowbat_valid);
        // Active ignores the standby battery threshold
        setraw(CMP_VBAT_STBY, 1'b1);
        setraw(CMP_LOWBAT24, 1'b1);
        step(4);
        chk("pa", 1, pa_en);
        rx(STATUS_ADDR, 8'h90);
        rx(STATUS_ADDR, 8'h90);
        setraw(CMP_LOWBAT24, 1'b0);
        setraw(CMP_VBAT_STBY, 1'b0);
        step(3);
        pulse(1);
        chk("state", ST_STANDBY, state);
        chk("lowbat_valid", 0, lowbat_valid);
        pulse(0);
        rx(STATUS_ADDR, 8'h80);
        setraw(CMP_LOWBAT21, 1'b1);
        step(3);
        rx(STATUS_ADDR, 8'hA0);
        setraw(CMP_LOWBAT21, 1'b0);
        // Dropout while transmitting
        setraw(CMP_REGSUP_ACT, 1'b1);
        step(1);
        chk("pa", 1, pa_en);
        step(1);
        chk("pa", 0, pa_en);
        step(1);
        chk("state", ST_POR, state);
        exp_cfg = '0;
        chk_cfg();
        setraw(CMP_REGSUP_ACT, 1'b0);
        step(1);
        chk("state", ST_STANDBY, state);
        rx(STATUS_ADDR, 8'hA4);
        // Battery dropout in standby
        wcfg(CFG_FIRST, 8'h3C);
        setraw(CMP_VBAT_STBY, 1'b1);
        step(3);
        chk("state", ST_POR, state);
        exp_cfg = '0;
        chk_cfg();
        setraw(CMP_VBAT_STBY, 1'b0);
        step(4);
        chk("state", ST_STANDBY, state);
        rx(STATUS_ADDR, 8'hA4);
        // Sleep loses the bank and refuses writes and starts
        wcfg(CFG_LAST, 8'hC3);
        pulse(2);
        chk("state", ST_SLEEP, state);
        exp_cfg = '0;
        step(1); // Bank clears on the first edge spent in sleep
        chk_cfg();
        host.wr(CFG_FIRST, 8'h11);
        pulse(0);
        chk("state", ST_SLEEP, state);
        chk_cfg();
        pulse(3);
        chk("state", ST_STANDBY, state);
        rx(STATUS_ADDR, 8'hA0);
        // Low clock enable freezes the controller, start is lost
        @(posedge i_sys_clk);
        i_clk_en <= 1'b0;
        pulse(0);
        chk("state", ST_STANDBY, state);
        @(posedge i_sys_clk);
        i_clk_en <= 1'b1;
        step(3);
        close_out();
    end
endmodule
